// ===== cbt_pkg.sv
// constants shared by the bit timing configuration block
// assumes a 100 MHz system clock and an apb master with 32-bit data
//
// Contract
// - timing registers writable in configuration mode only
// - jump width equals field plus one quanta
// - quantum is two times prescaler plus one
// - phase two free or max(phase one, ipt)
// - sample mode: three samples or one sample
// - phase one length is field plus one
// - propagation length is field plus one
// - wake-up disable bit blocks bus activity wake-up
// - filter bit routes wake-up through line filter
// - phase two length is field plus one
// - phase two field ignored when select clear
package cbt_pkg;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] PRESCALE_JUMP_WIDTH_CTRL_OFS = 8'h00;
    localparam logic [7:0] SEGMENT_SAMPLING_CTRL_OFS    = 8'h04;
    localparam logic [7:0] WAKEUP_PHASE2_CTRL_OFS       = 8'h08;
    localparam logic [7:0] MODE_CTRL_OFS                = 8'h0C;
    localparam logic [7:0] TIMING_STATUS_OFS            = 8'h10;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PRESCALER_LSB     = 0;
    localparam int JUMP_WIDTH_LSB    = 6;
    localparam int PROPAGATION_LSB   = 0;
    localparam int PHASE1_LSB        = 3;
    localparam int TRIPLE_SAMPLE_BIT = 6;
    localparam int PHASE2_FREE_BIT   = 7;
    localparam int PHASE2_LSB        = 0;
    localparam int WAKE_FILTER_BIT   = 6;
    localparam int WAKE_DISABLE_BIT  = 7;
    localparam int CONFIG_MODE_BIT   = 0;
    localparam int WAKE_SEEN_BIT     = 5;
    localparam logic [7:0] WAKEUP_PHASE2_MASK = 8'hC7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] TIMING_REG_RESET = 8'h00;
    localparam logic       CONFIG_MODE_RESET = 1'b1;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS       = 10;
    localparam int WAKE_FILTER_NS      = 50;
    localparam int WAKE_FILTER_CYCLES  = (WAKE_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] INFO_PROCESSING_QUANTA = 5'h02;
    localparam logic [4:0] SYNC_QUANTA            = 5'h01;

    // ------------------------------------------------------------
    // bit segment states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SEG_SYNC   = 4'b0001,
        SEG_PROP   = 4'b0010,
        SEG_PHASE1 = 4'b0100,
        SEG_PHASE2 = 4'b1000
    } cbt_seg_e;

    // field value plus one, as a quanta count
    function automatic logic [4:0] field_plus_one(input logic [2:0] f);
        field_plus_one = {2'b00, f} + 5'h01;
    endfunction : field_plus_one

endpackage : cbt_pkg

// ===== cbt_quantum_gen.sv
// time quantum tick generator
// assumes the prescaler value is stable while the generator runs
`timescale 1ns/10ps
module cbt_quantum_gen
    import cbt_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // control
    input  wire logic       run_in,
    input  wire logic [5:0] quantum_prescaler_in,
    // tick
    output logic            tq_tick_out
);
    import cbt_pkg::*;

    logic [6:0] cnt_q;
    logic [6:0] last;

    // period is 2 x (field + 1) clocks; field 63 gives 128
    assign last        = {quantum_prescaler_in, 1'b1};
    assign tq_tick_out = run_in && (cnt_q == last);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || !run_in || tq_tick_out)
            cnt_q <= 7'h00;
        else
            cnt_q <= cnt_q + 7'h01;
    end

endmodule : cbt_quantum_gen

// ===== cbt_bit_sampler.sv
// receive bit sampler with single or triple sampling
// assumes rx is already synchronous to the system clock
`timescale 1ns/10ps
module cbt_bit_sampler
    import cbt_pkg::*;
(
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // timing
    input  wire logic tq_tick_in,
    input  wire logic sample_point_in,
    input  wire logic triple_sample_select_in,
    // line and result
    input  wire logic rx_in,
    output logic      rx_bit_out
);
    import cbt_pkg::*;

    logic [1:0] hist_q;
    logic       majority;

    // two earlier quanta plus the sample point itself
    assign majority = (hist_q[0] & hist_q[1]) | (hist_q[0] & rx_in) | (hist_q[1] & rx_in);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            hist_q <= 2'b11;
        else if (tq_tick_in)
            hist_q <= {hist_q[0], rx_in};
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            rx_bit_out <= 1'b1;
        else if (sample_point_in)
            rx_bit_out <= triple_sample_select_in ? majority : rx_in;
    end

endmodule : cbt_bit_sampler

// ===== cbt_bit_timing.sv
// bit timing configuration registers and nominal bit segment timer
// assumes an apb master; zero wait state slave; rx is synchronous
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/10ps
module cbt_bit_timing
    import cbt_pkg::*;
(
    // clock and reset
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RST_N_IN,
    // apb slave
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    // can line and power state
    input  wire logic        CAN_RX_IN,
    input  wire logic        SLEEP_IN,
    // timing outputs
    output logic             TQ_TICK_OUT,
    output logic             BIT_START_OUT,
    output logic             SAMPLE_POINT_OUT,
    output logic             RX_BIT_OUT,
    output logic             CONFIG_MODE_OUT,
    output logic             WAKE_OUT
);
    import cbt_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] prescale_jump_width_ctrl_q;
    logic [7:0] segment_sampling_ctrl_q;
    logic [7:0] wakeup_phase2_ctrl_q;
    logic       config_mode_q;
    logic       wake_seen_q;
    cbt_seg_e   state_q;

    logic       access;
    logic       wr;
    logic       cfg_wr;
    logic       mapped;
    logic [31:0] rdata;

    // fields
    logic [1:0] resync_jump_width;
    logic [5:0] quantum_prescaler;
    logic       phase2_free_select;
    logic       triple_sample_select;
    logic [2:0] phase1_length;
    logic [2:0] propagation_length;
    logic       bus_wakeup_disable;
    logic       wakeup_line_filter_select;
    logic [2:0] phase2_length;

    assign resync_jump_width         = prescale_jump_width_ctrl_q[JUMP_WIDTH_LSB +: 2];
    assign quantum_prescaler         = prescale_jump_width_ctrl_q[PRESCALER_LSB +: 6];
    assign phase2_free_select        = segment_sampling_ctrl_q[PHASE2_FREE_BIT];
    assign triple_sample_select      = segment_sampling_ctrl_q[TRIPLE_SAMPLE_BIT];
    assign phase1_length             = segment_sampling_ctrl_q[PHASE1_LSB +: 3];
    assign propagation_length        = segment_sampling_ctrl_q[PROPAGATION_LSB +: 3];
    assign bus_wakeup_disable        = wakeup_phase2_ctrl_q[WAKE_DISABLE_BIT];
    assign wakeup_line_filter_select = wakeup_phase2_ctrl_q[WAKE_FILTER_BIT];
    assign phase2_length             = wakeup_phase2_ctrl_q[PHASE2_LSB +: 3];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign access      = PSEL_IN && PENABLE_IN;
    assign wr          = access && PWRITE_IN;
    assign cfg_wr      = wr && config_mode_q;
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = access && !mapped;

    always_comb
    begin
        mapped = 1'b1;
        rdata  = 32'h0000_0000;
        case (PADDR_IN)
            PRESCALE_JUMP_WIDTH_CTRL_OFS: rdata[7:0] = prescale_jump_width_ctrl_q;
            SEGMENT_SAMPLING_CTRL_OFS:    rdata[7:0] = segment_sampling_ctrl_q;
            WAKEUP_PHASE2_CTRL_OFS:       rdata[7:0] = wakeup_phase2_ctrl_q;
            MODE_CTRL_OFS:                rdata[CONFIG_MODE_BIT] = config_mode_q;
            TIMING_STATUS_OFS:            rdata[5:0] = {wake_seen_q, state_q, RX_BIT_OUT};
            default:                      mapped = 1'b0;
        endcase
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
            PRDATA_OUT <= 32'h0000_0000;
        else if (PSEL_IN && !PENABLE_IN && !PWRITE_IN)
            PRDATA_OUT <= rdata;
    end

    // timing registers: writes outside configuration mode are dropped
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
        begin
            prescale_jump_width_ctrl_q <= TIMING_REG_RESET;
            segment_sampling_ctrl_q    <= TIMING_REG_RESET;
            wakeup_phase2_ctrl_q       <= TIMING_REG_RESET;
        end
        else if (cfg_wr)
        begin
            if (PADDR_IN == PRESCALE_JUMP_WIDTH_CTRL_OFS)
                prescale_jump_width_ctrl_q <= PWDATA_IN[7:0];
            if (PADDR_IN == SEGMENT_SAMPLING_CTRL_OFS)
                segment_sampling_ctrl_q <= PWDATA_IN[7:0];
            if (PADDR_IN == WAKEUP_PHASE2_CTRL_OFS)
                wakeup_phase2_ctrl_q <= PWDATA_IN[7:0] & WAKEUP_PHASE2_MASK;
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
            config_mode_q <= CONFIG_MODE_RESET;
        else if (wr && PADDR_IN == MODE_CTRL_OFS)
            config_mode_q <= PWDATA_IN[CONFIG_MODE_BIT];
    end

    // sticky wake flag; a new wake beats a clear in the same cycle
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
            wake_seen_q <= 1'b0;
        else if (WAKE_OUT)
            wake_seen_q <= 1'b1;
        else if (wr && PADDR_IN == TIMING_STATUS_OFS && PWDATA_IN[WAKE_SEEN_BIT])
            wake_seen_q <= 1'b0;
    end

    assign CONFIG_MODE_OUT = config_mode_q;

    // ------------------------------------------------------------
    // segment lengths
    // ------------------------------------------------------------
    logic [4:0] prop_len;
    logic [4:0] ph1_len;
    logic [4:0] ph1_base;
    logic [4:0] ph2_len;
    logic [4:0] sjw_len;

    assign sjw_len  = {3'b000, resync_jump_width} + 5'h01;
    assign prop_len = field_plus_one(propagation_length);
    assign ph1_base = field_plus_one(phase1_length);

    // clear select ignores the programmed field entirely
    always_comb
    begin
        if (phase2_free_select)
            ph2_len = field_plus_one(phase2_length);
        else if (ph1_base > INFO_PROCESSING_QUANTA)
            ph2_len = ph1_base;
        else
            ph2_len = INFO_PROCESSING_QUANTA;
    end

    // ------------------------------------------------------------
    // segment state machine
    // ------------------------------------------------------------
    cbt_seg_e   state_d;
    logic [4:0] qcnt_q;
    logic [4:0] ext_q;
    logic [4:0] short_q;
    logic       resynced_q;
    logic       rx_prev_q;
    logic       run;
    logic       tick;
    logic       seg_end;
    logic       fall_edge;
    logic [4:0] err;
    logic [4:0] remain;

    assign run       = !config_mode_q;
    assign ph1_len   = ph1_base + ext_q;
    assign fall_edge = tick && rx_prev_q && !CAN_RX_IN && !resynced_q;
    assign remain    = ph2_len - qcnt_q;

    cbt_quantum_gen u_quantum
    (
        .clk_in               (CLK_SYS_IN),
        .rst_n_in             (RST_N_IN),
        .run_in               (run),
        .quantum_prescaler_in (quantum_prescaler),
        .tq_tick_out          (tick)
    );

    always_comb
    begin
        seg_end = 1'b0;
        state_d = state_q;
        err     = 5'h00;
        case (state_q)
            SEG_SYNC:
            begin
                seg_end = (qcnt_q == SYNC_QUANTA - 5'h01);
                state_d = SEG_PROP;
            end
            SEG_PROP:
            begin
                seg_end = (qcnt_q == prop_len - 5'h01);
                state_d = SEG_PHASE1;
                err     = qcnt_q + 5'h01;
            end
            SEG_PHASE1:
            begin
                seg_end = (qcnt_q == ph1_len - 5'h01);
                state_d = SEG_PHASE2;
                err     = prop_len + qcnt_q + 5'h01;
            end
            SEG_PHASE2:
            begin
                seg_end = (qcnt_q + short_q == ph2_len - 5'h01)
                          || (fall_edge && remain <= sjw_len);
                state_d = SEG_SYNC;
            end
            default:
            begin
                seg_end = 1'b1;
                state_d = SEG_SYNC;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN || !run)
        begin
            state_q <= SEG_SYNC;
            qcnt_q  <= 5'h00;
        end
        else if (tick)
        begin
            if (seg_end)
            begin
                state_q <= state_d;
                qcnt_q  <= 5'h00;
            end
            else
                qcnt_q <= qcnt_q + 5'h01;
        end
    end

    // resynchronisation: late edge stretches phase one, early edge cuts phase two
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN || !run)
        begin
            ext_q      <= 5'h00;
            short_q    <= 5'h00;
            resynced_q <= 1'b0;
        end
        else if (tick && seg_end && state_q == SEG_PHASE2)
        begin
            ext_q      <= 5'h00;
            short_q    <= 5'h00;
            resynced_q <= 1'b0;
        end
        else if (fall_edge && state_q != SEG_SYNC)
        begin
            resynced_q <= 1'b1;
            if (state_q == SEG_PHASE2)
                short_q <= sjw_len;
            else
                ext_q <= (err < sjw_len) ? err : sjw_len;
        end
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
            rx_prev_q <= 1'b1;
        else if (tick)
            rx_prev_q <= CAN_RX_IN;
    end

    // sample point is the end of phase one
    assign SAMPLE_POINT_OUT = tick && seg_end && state_q == SEG_PHASE1;
    assign BIT_START_OUT    = tick && seg_end && state_q == SEG_PHASE2;
    assign TQ_TICK_OUT      = tick;

    cbt_bit_sampler u_sampler
    (
        .clk_in                  (CLK_SYS_IN),
        .rst_n_in                (RST_N_IN),
        .tq_tick_in              (tick),
        .sample_point_in         (SAMPLE_POINT_OUT),
        .triple_sample_select_in (triple_sample_select),
        .rx_in                   (CAN_RX_IN),
        .rx_bit_out              (RX_BIT_OUT)
    );

    // ------------------------------------------------------------
    // bus activity wake-up
    // ------------------------------------------------------------
    // filter rejects dominant glitches shorter than the filter time
    logic [7:0] low_cnt_q;
    logic       filtered_low;
    logic       raw_low;
    logic       armed_q;
    logic       wake_req;

    assign filtered_low = (low_cnt_q >= 8'(WAKE_FILTER_CYCLES));
    assign raw_low      = !CAN_RX_IN;
    assign wake_req     = SLEEP_IN && !bus_wakeup_disable
                          && (wakeup_line_filter_select ? filtered_low : raw_low);

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN || CAN_RX_IN)
            low_cnt_q <= 8'h00;
        else if (!filtered_low)
            low_cnt_q <= low_cnt_q + 8'h01;
    end

    // one pulse per sleep period
    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN || !SLEEP_IN)
            armed_q <= 1'b1;
        else if (wake_req)
            armed_q <= 1'b0;
    end

    always_ff @(posedge CLK_SYS_IN)
    begin
        if (!RST_N_IN)
            WAKE_OUT <= 1'b0;
        else
            WAKE_OUT <= wake_req && armed_q;
    end

endmodule : cbt_bit_timing

// ===== cbt_bit_timing_monitor.sv
// checker on the ports of the bit timing block
// assumes one clock domain with a synchronous active low reset
`timescale 1ns/10ps
module cbt_bit_timing_monitor (
    // clock and reset
    input wire logic        CLK_SYS_IN,
    input wire logic        RST_N_IN,
    // apb slave
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [7:0]  PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    // line and power state
    input wire logic        CAN_RX_IN,
    input wire logic        SLEEP_IN,
    // timing outputs
    input wire logic        TQ_TICK_OUT,
    input wire logic        BIT_START_OUT,
    input wire logic        SAMPLE_POINT_OUT,
    input wire logic        RX_BIT_OUT,
    input wire logic        CONFIG_MODE_OUT,
    input wire logic        WAKE_OUT
);
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (!RST_N_IN);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    chk_tick_idle_cfg: assert property (CONFIG_MODE_OUT |-> !TQ_TICK_OUT)
        else $error("quantum tick in configuration mode");
    chk_tick_gap_min: assert property (TQ_TICK_OUT |=> !TQ_TICK_OUT)
        else $error("quantum ticks closer than two cycles");
    chk_tick_gap_max: assert property (TQ_TICK_OUT |=> ##[0:127] (TQ_TICK_OUT || CONFIG_MODE_OUT))
        else $error("quantum tick missing after 128 cycles");
    chk_sample_on_tick: assert property (SAMPLE_POINT_OUT |-> TQ_TICK_OUT && !BIT_START_OUT)
        else $error("sample point off a quantum boundary");
    chk_start_on_tick: assert property (BIT_START_OUT |-> TQ_TICK_OUT)
        else $error("bit start off a quantum boundary");
    chk_rx_bit_hold: assert property (!$past(SAMPLE_POINT_OUT) && $past(RST_N_IN) |-> $stable(RX_BIT_OUT))
        else $error("received bit changed away from sample point");
    chk_wake_asleep: assert property (WAKE_OUT |-> $past(SLEEP_IN))
        else $error("wake pulse while awake");
    chk_wake_single: assert property (WAKE_OUT |=> !WAKE_OUT)
        else $error("wake pulse longer than one cycle");
    chk_err_unmapped: assert property (PSEL_IN && PENABLE_IN |->
        PSLVERR_OUT == !(PADDR_IN inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
        else $error("slave error flag wrong for address");
    // ------------------------------------------------------------
    // cover
    // ------------------------------------------------------------
    cov_sample: cover property (SAMPLE_POINT_OUT);
    cov_wake: cover property (WAKE_OUT);
    cov_error: cover property (PSEL_IN && PENABLE_IN && PSLVERR_OUT);
endmodule : cbt_bit_timing_monitor

bind cbt_bit_timing cbt_bit_timing_monitor u_monitor (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
    .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .CAN_RX_IN(CAN_RX_IN), .SLEEP_IN(SLEEP_IN),
    .TQ_TICK_OUT(TQ_TICK_OUT), .BIT_START_OUT(BIT_START_OUT),
    .SAMPLE_POINT_OUT(SAMPLE_POINT_OUT), .RX_BIT_OUT(RX_BIT_OUT),
    .CONFIG_MODE_OUT(CONFIG_MODE_OUT), .WAKE_OUT(WAKE_OUT));

// ===== cbt_can_node.sv
// far side bus node seen through a line transceiver
// assumes the bench asks for dominant levels on rising edges
`timescale 1ns/10ps
module cbt_can_node (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    // request and line
    input  wire logic dominant_in,
    output logic      rx_out
);
    // ------------------------------------------------------------
    // line driver
    // ------------------------------------------------------------
    // released line falls back to recessive, its pulled idle level
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
            rx_out <= 1'b1;
        else
            rx_out <= ~dominant_in;
    end
endmodule : cbt_can_node

// ===== testbench.sv
// self-checking bench for the bit timing block
// assumes the node model drives the line and apb answers at once
`timescale 1ns/10ps
module testbench;
    import cbt_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        sleep = 1'b0;
    logic        dom = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, can_rx, tq_tick, bit_start, sample_pt, rx_bit, cfg, wake;
    logic [32:0] exp_q[$];
    int          mismatches = 0;
    int          comparisons = 0;
    int          wakes = 0;
    int          cycles = 0;
    int          seed = 32'h4C49DA20;
    int          wk_len [4] = '{1, 8, 4, 5};
    int          wk_exp [4] = '{1, 0, 0, 1};
    logic [7:0]  wk_cfg [4] = '{8'h00, 8'h80, 8'h40, 8'h40};

    cbt_bit_timing dut (
        .CLK_SYS_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CAN_RX_IN(can_rx),
        .SLEEP_IN(sleep), .TQ_TICK_OUT(tq_tick), .BIT_START_OUT(bit_start),
        .SAMPLE_POINT_OUT(sample_pt), .RX_BIT_OUT(rx_bit), .CONFIG_MODE_OUT(cfg),
        .WAKE_OUT(wake));
    cbt_can_node node (.clk_in(clk), .rst_n_in(rst_n), .dominant_in(dom), .rx_out(can_rx));

    always #5 clk = ~clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task final_report;
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    task check(input logic [32:0] got, input logic [32:0] want);
        comparisons++;
        if (got !== want)
        begin
            mismatches++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, want);
        end
    endtask : check

    // e holds the slave error flag above the expected read byte
    task apb(input logic wr, input logic [7:0] a, input logic [7:0] d, input logic [8:0] e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        if (!wr)
            exp_q.push_back({e[8], 24'h0, e[7:0]});
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // outputs are looked at on the falling edge, where they are settled
    task measure(input int per, input int n1, input int n2);
        int t;
        int c;
        t = 0;
        do @(negedge clk); while (bit_start !== 1'b1);
        do begin @(negedge clk); t++; end while (tq_tick !== 1'b1);
        check(33'(t), 33'(per));
        c = 1;
        while (sample_pt !== 1'b1)
        begin
            @(negedge clk);
            if (tq_tick === 1'b1)
                c++;
        end
        check(33'(c), 33'(n1));
        c = 0;
        do begin @(negedge clk); if (tq_tick === 1'b1) c++; end while (bit_start !== 1'b1);
        check(33'(c), 33'(n2));
    endtask : measure

    // ------------------------------------------------------------
    // result watcher and timeout
    // ------------------------------------------------------------
    always @(negedge clk)
    begin
        if (wake === 1'b1)
            wakes++;
    end

    // read data is taken at the edge that completes the access
    always @(posedge clk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            check({pslverr, prdata}, exp_q.pop_front());
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            final_report();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        int         ph2;
        int         w0;
        int         n;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, PRESCALE_JUMP_WIDTH_CTRL_OFS, 8'h00, 9'h000);
        apb(1'b0, SEGMENT_SAMPLING_CTRL_OFS, 8'h00, 9'h000);
        apb(1'b0, WAKEUP_PHASE2_CTRL_OFS, 8'h00, 9'h000);
        apb(1'b0, MODE_CTRL_OFS, 8'h00, 9'h001);
        apb(1'b0, 8'h14, 8'h00, 9'h100);
        for (int i = 0; i < 4; i++)
        begin
            b1 = 8'($random(seed)) & 8'hC3;
            b2 = {i[0], i[1], 6'($random(seed))};
            b3 = 8'($random(seed));
            ph2 = i[0] ? b3[2:0] + 1 : ((b2[5:3] + 1 > 2) ? b2[5:3] + 1 : 2);
            apb(1'b1, MODE_CTRL_OFS, 8'h01, 9'h000);
            apb(1'b1, PRESCALE_JUMP_WIDTH_CTRL_OFS, b1, 9'h000);
            apb(1'b1, SEGMENT_SAMPLING_CTRL_OFS, b2, 9'h000);
            apb(1'b1, WAKEUP_PHASE2_CTRL_OFS, b3, 9'h000);
            apb(1'b0, SEGMENT_SAMPLING_CTRL_OFS, 8'h00, {1'b0, b2});
            apb(1'b0, WAKEUP_PHASE2_CTRL_OFS, 8'h00, {1'b0, b3 & WAKEUP_PHASE2_MASK});
            apb(1'b1, MODE_CTRL_OFS, 8'h00, 9'h000);
            check(33'(cfg), 33'h0);
            apb(1'b1, PRESCALE_JUMP_WIDTH_CTRL_OFS, ~b1, 9'h000);
            apb(1'b0, PRESCALE_JUMP_WIDTH_CTRL_OFS, 8'h00, {1'b0, b1});
            measure(2 * (b1[5:0] + 1), b2[2:0] + b2[5:3] + 3, ph2);
            @(posedge clk);
            dom <= b3[0];
            do @(negedge clk); while (sample_pt !== 1'b1);
            @(negedge clk);
            check(33'(rx_bit), 33'(!b3[0]));
            // flip just before the sample point: triple mode keeps the old level
            n = 0;
            do @(negedge clk); while (bit_start !== 1'b1);
            while (n < b2[2:0] + b2[5:3] + 2)
            begin
                @(negedge clk);
                if (tq_tick === 1'b1)
                    n++;
            end
            @(posedge clk);
            dom <= ~b3[0];
            do @(negedge clk); while (sample_pt !== 1'b1);
            @(negedge clk);
            check(33'(rx_bit), 33'(b3[0] ^ i[1]));
            @(posedge clk);
            dom <= 1'b0;
        end
        apb(1'b1, MODE_CTRL_OFS, 8'h01, 9'h000);
        // raw, disabled, filtered too short, filtered just long enough
        for (int k = 0; k < 4; k++)
        begin
            w0 = wakes;
            apb(1'b1, WAKEUP_PHASE2_CTRL_OFS, wk_cfg[k], 9'h000);
            sleep <= 1'b1;
            repeat (3) @(posedge clk);
            dom <= 1'b1;
            repeat (wk_len[k]) @(posedge clk);
            dom <= 1'b0;
            repeat (10) @(posedge clk);
            sleep <= 1'b0;
            @(posedge clk);
            check(33'(wakes - w0), 33'(wk_exp[k]));
        end
        // sticky wake flag, then a written one clears it
        apb(1'b0, TIMING_STATUS_OFS, 8'h00, {3'b000, 1'b1, 4'b0001, !b3[0]});
        apb(1'b1, TIMING_STATUS_OFS, 8'h20, 9'h000);
        apb(1'b0, TIMING_STATUS_OFS, 8'h00, {3'b000, 1'b0, 4'b0001, !b3[0]});
        final_report();
    end
endmodule : testbench
